// file: common/txhc_pkg.sv
// Constants and types shared by the transmit control and setup registers.
package txhc_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 12;
    localparam logic [11:0] TRANSMIT_CONTROL_OFS = 12'h010;
    localparam logic [11:0] HARDWARE_SETUP_OFS = 12'h014;

    localparam int TX_FLUSH_BIT = 0;
    localparam int TX_HALT_REQ_BIT = 1;
    localparam int TX_ENABLE_BIT = 2;

    localparam int RESET_PROTECT_BIT = 15;
    localparam int EMULATION_SELECT_BIT = 16;
    localparam int DETACH_REQUEST_BIT = 17;
    localparam int DETACH_WAKE_FLAG_BIT = 18;

    localparam logic TX_ENABLE_RESET = 1'b0;
    localparam logic TX_HALT_REQ_RESET = 1'b0;
    localparam logic TX_FLUSH_RESET = 1'b0;
    localparam logic RESET_PROTECT_RESET = 1'b0;
    localparam logic EMULATION_SELECT_RESET = 1'b0;
    localparam logic DETACH_REQUEST_RESET = 1'b0;
    localparam logic DETACH_WAKE_FLAG_RESET = 1'b0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int DETACH_HOLD_NS = 1000;
    localparam int DETACH_HOLD_CYCLES =
        (DETACH_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int HOLD_W = 8;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        HALT_IDLE = 2'b00,
        HALT_DRAIN = 2'b01,
        HALT_DONE = 2'b11,
        HALT_SETTLE = 2'b10
    } txhc_halt_state_t;

    typedef enum logic [1:0] {
        BUS_ATTACHED = 2'b00,
        BUS_HOLD = 2'b01,
        BUS_DETACHED = 2'b11,
        BUS_WAKE = 2'b10
    } txhc_bus_state_t;

endpackage : txhc_pkg

// file: rtl/txhc_halt_ctrl.sv
// Graceful transmitter halt sequencer.
`timescale 1ns/100ps
module txhc_halt_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic softReset,
    input wire logic haltRequest,
    input wire logic frameBusy,
    input wire logic pipeIdle,
    output logic haltDone
);

    typedef struct packed {
        txhc_pkg::txhc_halt_state_t state;
        logic pulse;
    } txhc_halt_regs_t;

    txhc_halt_regs_t s;
    txhc_halt_regs_t next_s;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.pulse = 1'b0;
        unique case (s.state)
            txhc_pkg::HALT_IDLE: begin
                if (haltRequest) begin
                    next_s.state = txhc_pkg::HALT_DRAIN;
                end
            end
            txhc_pkg::HALT_DRAIN: begin
                // The frame in flight is finished and the pipe emptied.
                if (!frameBusy && pipeIdle) begin
                    next_s.state = txhc_pkg::HALT_DONE;
                    next_s.pulse = 1'b1;
                end
            end
            txhc_pkg::HALT_DONE: begin
                next_s.state = txhc_pkg::HALT_SETTLE;
            end
            txhc_pkg::HALT_SETTLE: begin
                next_s.state = txhc_pkg::HALT_IDLE;
            end
        endcase
        if (softReset) begin
            next_s.state = txhc_pkg::HALT_IDLE;
            next_s.pulse = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{state: txhc_pkg::HALT_IDLE, pulse: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign haltDone = s.pulse;

endmodule : txhc_halt_ctrl

// file: rtl/txhc_bus_detach.sv
// Bus detach and wake sequencer.
`timescale 1ns/100ps
module txhc_bus_detach #(
    parameter int HOLD_CYCLES = txhc_pkg::DETACH_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic softReset,
    input wire logic detachStart,
    input wire logic linkUp,
    input wire logic gpioWake,
    output logic usbDetach,
    output logic wakeEvent
);

    localparam logic [txhc_pkg::HOLD_W-1:0] HOLD_LAST =
        txhc_pkg::HOLD_W'(HOLD_CYCLES - 1);

    typedef struct packed {
        txhc_pkg::txhc_bus_state_t state;
        logic [txhc_pkg::HOLD_W-1:0] count;
        logic detach;
        logic wake;
    } txhc_bus_regs_t;

    txhc_bus_regs_t s;
    txhc_bus_regs_t next_s;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.wake = 1'b0;
        unique case (s.state)
            txhc_pkg::BUS_ATTACHED: begin
                if (detachStart) begin
                    next_s.state = txhc_pkg::BUS_HOLD;
                    next_s.detach = 1'b1;
                    next_s.count = '0;
                end
            end
            txhc_pkg::BUS_HOLD: begin
                // A short floor keeps the host from seeing a glitch.
                if (s.count == HOLD_LAST) begin
                    next_s.state = txhc_pkg::BUS_DETACHED;
                end else begin
                    next_s.count = s.count + 1'b1;
                end
            end
            txhc_pkg::BUS_DETACHED: begin
                if (linkUp || gpioWake) begin
                    next_s.state = txhc_pkg::BUS_WAKE;
                    next_s.detach = 1'b0;
                    next_s.wake = 1'b1;
                end
            end
            txhc_pkg::BUS_WAKE: begin
                next_s.state = txhc_pkg::BUS_ATTACHED;
            end
        endcase
        if (softReset) begin
            next_s.state = txhc_pkg::BUS_ATTACHED;
            next_s.detach = 1'b0;
            next_s.wake = 1'b0;
            next_s.count = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{state: txhc_pkg::BUS_ATTACHED, count: '0,
                   detach: 1'b0, wake: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign usbDetach = s.detach;
    assign wakeEvent = s.wake;

endmodule : txhc_bus_detach

// file: rtl/txhc_regs.sv
// Transmit control and hardware setup registers behind an APB slave.
//
// Summary of operation
// - Enable bit set: transmitter runs, FIFO drains.
// - Enable clears itself after requested halt completes.
// - Halt request finishes current frame, then stops.
// - Halt request bit clears once transmitter stopped.
// - Writes to halt request ignored while set.
// - Halt clears only with datapath empty.
// - Flush bit resets FIFO pointers, self-clears.
// - Sticky detach-wake flag, cleared by writing one.
// - Detach request disconnects device from USB.
// - On wake reattach and set detach-wake flag.
// - Emulation select picks defaults or descriptor RAM.
// - Emulation select ignored when EEPROM present.
// - Emulation select is a reset-guarded field.
// - Guarded fields survive soft resets when protected.
// - Pulse transmit-halted event when requested halt completes.
`timescale 1ns/100ps
module txhc_regs #(
    parameter int DETACH_HOLD = txhc_pkg::DETACH_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic softReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [txhc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frameBusy,
    input wire logic pipeIdle,
    input wire logic linkUp,
    input wire logic gpioWake,
    input wire logic eepromPresent,
    output logic txEnable,
    output logic txHaltRequest,
    output logic txStartAllow,
    output logic txFifoFlush,
    output logic transmitHaltedEvent,
    output logic usbDetach,
    output logic descriptorFromRam,
    output logic resetProtect
);

    ////////////////////////////////////////////////////////////////////////
    // Register state. Guarded fields share one struct with the rest; the soft
    // reset branch spares them by testing the protection bit.

    typedef struct packed {
        logic txOn;
        logic haltReq;
        logic flush;
        logic detachReq;
        logic wakeFlag;
        logic emulation;
        logic protect;
        logic startAllow;
        logic fromRam;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } txhc_reg_state_t;

    txhc_reg_state_t s;
    txhc_reg_state_t next_s;

    logic haltDone;
    logic wakeEvent;
    logic detachOut;

    ////////////////////////////////////////////////////////////////////////
    // Byte lane of a bit position, used for every field write.

    function automatic logic laneOn(input logic [3:0] strb, input int pos);
        laneOn = strb[pos / 8];
    endfunction : laneOn

    function automatic logic isMapped(
        input logic [txhc_pkg::ADDR_W-1:0] addr
    );
        isMapped = (addr == txhc_pkg::TRANSMIT_CONTROL_OFS) ||
                   (addr == txhc_pkg::HARDWARE_SETUP_OFS);
    endfunction : isMapped

    ////////////////////////////////////////////////////////////////////////
    // Read views of both registers, built from current state.

    function automatic logic [31:0] readView(
        input logic [txhc_pkg::ADDR_W-1:0] addr,
        input txhc_reg_state_t st
    );
        logic [31:0] v;
        v = txhc_pkg::READ_ZERO;
        if (addr == txhc_pkg::TRANSMIT_CONTROL_OFS) begin
            v[txhc_pkg::TX_ENABLE_BIT] = st.txOn;
            v[txhc_pkg::TX_HALT_REQ_BIT] = st.haltReq;
            v[txhc_pkg::TX_FLUSH_BIT] = st.flush;
        end else if (addr == txhc_pkg::HARDWARE_SETUP_OFS) begin
            v[txhc_pkg::DETACH_WAKE_FLAG_BIT] = st.wakeFlag;
            v[txhc_pkg::DETACH_REQUEST_BIT] = st.detachReq;
            v[txhc_pkg::EMULATION_SELECT_BIT] = st.emulation;
            v[txhc_pkg::RESET_PROTECT_BIT] = st.protect;
        end
        readView = v;
    endfunction : readView

    ////////////////////////////////////////////////////////////////////////
    // Sub-sequencers.

    txhc_halt_ctrl u_halt (
        .clock(clock),
        .rst(rst),
        .softReset(softReset),
        .haltRequest(s.haltReq),
        .frameBusy(frameBusy),
        .pipeIdle(pipeIdle),
        .haltDone(haltDone)
    );

    txhc_bus_detach #(
        .HOLD_CYCLES(DETACH_HOLD)
    ) u_detach (
        .clock(clock),
        .rst(rst),
        .softReset(softReset),
        .detachStart(s.detachReq),
        .linkUp(linkUp),
        .gpioWake(gpioWake),
        .usbDetach(detachOut),
        .wakeEvent(wakeEvent)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    logic setupPhase;
    logic writeNow;
    logic wrTx;
    logic wrHw;

    always_comb begin
        setupPhase = psel && !penable;
        writeNow = psel && penable && s.ready && pwrite &&
                   isMapped(paddr);
        wrTx = writeNow && (paddr == txhc_pkg::TRANSMIT_CONTROL_OFS);
        wrHw = writeNow && (paddr == txhc_pkg::HARDWARE_SETUP_OFS);

        next_s = s;

        // Self-clearing bits stand for one cycle after the write.
        next_s.flush = 1'b0;
        next_s.detachReq = 1'b0;

        // APB answers in the cycle after setup: no wait states.
        next_s.ready = setupPhase;
        next_s.slverr = setupPhase && !isMapped(paddr);
        if (setupPhase) begin
            next_s.rdata = pwrite ? txhc_pkg::READ_ZERO
                                  : readView(paddr, s);
        end else begin
            next_s.rdata = txhc_pkg::READ_ZERO;
        end

        // Transmit control writes.
        if (wrTx && laneOn(pstrb, txhc_pkg::TX_ENABLE_BIT)) begin
            next_s.txOn = pwdata[txhc_pkg::TX_ENABLE_BIT];
        end
        if (wrTx && laneOn(pstrb, txhc_pkg::TX_HALT_REQ_BIT) &&
            !s.haltReq) begin
            next_s.haltReq = pwdata[txhc_pkg::TX_HALT_REQ_BIT];
        end
        if (wrTx && laneOn(pstrb, txhc_pkg::TX_FLUSH_BIT)) begin
            next_s.flush = pwdata[txhc_pkg::TX_FLUSH_BIT];
        end

        // A finished halt drops both the request and the enable; the
        // sequencer only reports done once the datapath is empty.
        if (haltDone) begin
            next_s.haltReq = 1'b0;
            next_s.txOn = 1'b0;
        end

        // Hardware setup writes.
        if (wrHw && laneOn(pstrb, txhc_pkg::DETACH_REQUEST_BIT)) begin
            next_s.detachReq = pwdata[txhc_pkg::DETACH_REQUEST_BIT];
        end
        if (wrHw && laneOn(pstrb, txhc_pkg::EMULATION_SELECT_BIT)) begin
            next_s.emulation = pwdata[txhc_pkg::EMULATION_SELECT_BIT];
        end
        if (wrHw && laneOn(pstrb, txhc_pkg::RESET_PROTECT_BIT)) begin
            next_s.protect = pwdata[txhc_pkg::RESET_PROTECT_BIT];
        end
        if (wrHw && laneOn(pstrb, txhc_pkg::DETACH_WAKE_FLAG_BIT) &&
            pwdata[txhc_pkg::DETACH_WAKE_FLAG_BIT]) begin
            next_s.wakeFlag = 1'b0;
        end
        // A wake in the same cycle as a clear keeps the flag set.
        if (wakeEvent) begin
            next_s.wakeFlag = 1'b1;
        end

        // Soft reset clears every control field but not the APB response, except guarded fields when the
        // protection bit is set; only the power-on reset reaches those.
        if (softReset) begin
            next_s.txOn = txhc_pkg::TX_ENABLE_RESET;
            next_s.haltReq = txhc_pkg::TX_HALT_REQ_RESET;
            next_s.flush = txhc_pkg::TX_FLUSH_RESET;
            next_s.detachReq = txhc_pkg::DETACH_REQUEST_RESET;
            next_s.wakeFlag = txhc_pkg::DETACH_WAKE_FLAG_RESET;
            if (!s.protect) begin
                next_s.emulation = txhc_pkg::EMULATION_SELECT_RESET;
                next_s.protect = txhc_pkg::RESET_PROTECT_RESET;
            end
        end

        // No new frame while disabled or while a halt is pending.
        next_s.startAllow = next_s.txOn && !next_s.haltReq;

        // Descriptor source: EEPROM wins, else the emulation select.
        next_s.fromRam = next_s.emulation && !eepromPresent;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register. rst is the power-on reset and clears all fields.

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '{txOn: txhc_pkg::TX_ENABLE_RESET,
                   haltReq: txhc_pkg::TX_HALT_REQ_RESET,
                   flush: txhc_pkg::TX_FLUSH_RESET,
                   detachReq: txhc_pkg::DETACH_REQUEST_RESET,
                   wakeFlag: txhc_pkg::DETACH_WAKE_FLAG_RESET,
                   emulation: txhc_pkg::EMULATION_SELECT_RESET,
                   protect: txhc_pkg::RESET_PROTECT_RESET,
                   startAllow: 1'b0,
                   fromRam: 1'b0,
                   rdata: txhc_pkg::READ_ZERO,
                   ready: 1'b0,
                   slverr: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each a flip-flop of this block or of a sequencer.

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;
    assign txEnable = s.txOn;
    assign txHaltRequest = s.haltReq;
    assign txStartAllow = s.startAllow;
    assign txFifoFlush = s.flush;
    assign transmitHaltedEvent = haltDone;
    assign usbDetach = detachOut;
    assign descriptorFromRam = s.fromRam;
    assign resetProtect = s.protect;

endmodule : txhc_regs

// file: tb/txhc_regs_checker.sv
// Concurrent checks on the ports of the transmit control registers.
`timescale 1ns/100ps
module txhc_regs_checker #(
    parameter int DETACH_HOLD = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic softReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [txhc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frameBusy,
    input wire logic pipeIdle,
    input wire logic linkUp,
    input wire logic gpioWake,
    input wire logic eepromPresent,
    input wire logic txEnable,
    input wire logic txHaltRequest,
    input wire logic txStartAllow,
    input wire logic txFifoFlush,
    input wire logic transmitHaltedEvent,
    input wire logic usbDetach,
    input wire logic descriptorFromRam
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic flushWrite;
    assign flushWrite = psel && penable && pready && pwrite && pstrb[0]
        && paddr == txhc_pkg::TRANSMIT_CONTROL_OFS && pwdata[0];
    ////////////////////////////////////////////////////////////////////////
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_start_gate: assert property (
        txStartAllow == (txEnable && !txHaltRequest))
        else $error("start permission wrong");
    chk_halt_cause: assert property (
        transmitHaltedEvent |-> $past(txHaltRequest && !frameBusy && pipeIdle))
        else $error("halt event without idle datapath");
    chk_halt_finish: assert property (
        transmitHaltedEvent |=> !transmitHaltedEvent && !txHaltRequest
        && !txEnable) else $error("halt did not finish");
    chk_halt_hold: assert property (
        txHaltRequest && frameBusy && !softReset && !transmitHaltedEvent
        |=> txHaltRequest)
        else $error("halt request dropped mid frame");
    chk_flush_cause: assert property (
        txFifoFlush |-> $past(flushWrite) && !$past(txFifoFlush))
        else $error("flush pulse wrong");
    chk_emulation_gate: assert property (
        descriptorFromRam |-> !$past(eepromPresent))
        else $error("emulation used with eeprom");
    chk_detach_stay: assert property (
        usbDetach && !linkUp && !gpioWake && !softReset |=> usbDetach)
        else $error("detach ended without wake");
    chk_wake_cause: assert property (
        $fell(usbDetach) |-> $past(linkUp || gpioWake || softReset))
        else $error("reattach without cause");
    cover property (transmitHaltedEvent);
    cover property (txFifoFlush);
    cover property ($fell(usbDetach));
endmodule : txhc_regs_checker

bind txhc_regs txhc_regs_checker #(.DETACH_HOLD(DETACH_HOLD)) u_chk (
    .clock(clock), .rst(rst), .softReset(softReset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .frameBusy(frameBusy), .pipeIdle(pipeIdle), .linkUp(linkUp),
    .gpioWake(gpioWake), .eepromPresent(eepromPresent),
    .txEnable(txEnable), .txHaltRequest(txHaltRequest),
    .txStartAllow(txStartAllow), .txFifoFlush(txFifoFlush),
    .transmitHaltedEvent(transmitHaltedEvent), .usbDetach(usbDetach),
    .descriptorFromRam(descriptorFromRam));

// file: tb/tx_control_and_hw_config_bench.sv
// Self-checking bench for the transmit control and setup registers.
`timescale 1ns/100ps
module tx_control_and_hw_config_bench;
    localparam logic [11:0] TXC = txhc_pkg::TRANSMIT_CONTROL_OFS;
    localparam logic [11:0] HWS = txhc_pkg::HARDWARE_SETUP_OFS;
    logic clock = 1'h0, rst = 1'h1, softReset = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err;
    logic frameBusy = 1'h1, pipeIdle = 1'h0, linkUp = 1'h0;
    logic gpioWake = 1'h0, eepromPresent = 1'h0;
    logic txEnable, txHaltRequest, txStartAllow, txFifoFlush;
    logic transmitHaltedEvent, usbDetach, descriptorFromRam, resetProtect;
    int mismatches = 0, cmpCount = 0, cycles = 0, n;

    // A short detach hold keeps the wake tests quick.
    txhc_regs #(.DETACH_HOLD(2)) u_dut (
        .clock(clock), .rst(rst), .softReset(softReset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frameBusy(frameBusy),
        .pipeIdle(pipeIdle), .linkUp(linkUp), .gpioWake(gpioWake),
        .eepromPresent(eepromPresent), .txEnable(txEnable),
        .txHaltRequest(txHaltRequest), .txStartAllow(txStartAllow),
        .txFifoFlush(txFifoFlush),
        .transmitHaltedEvent(transmitHaltedEvent),
        .usbDetach(usbDetach), .descriptorFromRam(descriptorFromRam),
        .resetProtect(resetProtect));

    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            completeRun();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task completeRun();
        $display("compares %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : completeRun

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // The request is held until pready is seen high at a rising edge.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1);
        // The slave answers in the first access cycle, with no wait state.
        check(32'(n), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= 1'h0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    task pulseSoftReset();
        @(posedge clock);
        softReset <= 1'h1;
        @(posedge clock);
        softReset <= 1'h0;
    endtask : pulseSoftReset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'h0;
        rdchk(TXC, 32'h0);
        rdchk(HWS, 32'h0);
        apb(1'h1, 12'h018, 32'hffff_ffff);
        check({31'h0, err}, 32'h1);
        rdchk(12'h018, 32'h0);
        apb(1'h1, TXC, 32'hffff_fff8);
        rdchk(TXC, 32'h0);
        $display("test reset done");
        apb(1'h1, TXC, 32'h4);
        #1 check({30'h0, txEnable, txStartAllow}, 32'h3);
        apb(1'h1, TXC, 32'h6);
        #1 check({30'h0, txHaltRequest, txStartAllow}, 32'h2);
        apb(1'h1, TXC, 32'h4);
        rdchk(TXC, 32'h6);
        frameBusy <= 1'h0;
        repeat (3) @(posedge clock);
        check({31'h0, txHaltRequest}, 32'h1);
        pipeIdle <= 1'h1;
        for (n = 0; n < 20 && transmitHaltedEvent !== 1'h1; n++) begin
            @(posedge clock);
        end
        check({31'h0, transmitHaltedEvent}, 32'h1);
        @(posedge clock);
        #1 check({30'h0, txHaltRequest, txEnable}, 32'h0);
        rdchk(TXC, 32'h0);
        $display("test halt done");
        apb(1'h1, TXC, 32'h1);
        #1 check({31'h0, txFifoFlush}, 32'h1);
        @(posedge clock);
        #1 check({31'h0, txFifoFlush}, 32'h0);
        rdchk(TXC, 32'h0);
        $display("test flush done");
        for (int s = 0; s < 2; s++) begin
            apb(1'h1, HWS, 32'h0002_0000);
            repeat (10) @(posedge clock);
            #1 check({31'h0, usbDetach}, 32'h1);
            rdchk(HWS, 32'h0);
            {linkUp, gpioWake} <= (s == 0) ? 2'h1 : 2'h2;
            for (n = 0; n < 20 && usbDetach !== 1'h0; n++) begin
                @(posedge clock);
            end
            {linkUp, gpioWake} <= 2'h0;
            check({31'h0, usbDetach}, 32'h0);
            rdchk(HWS, 32'h0004_0000);
            apb(1'h1, HWS, 32'h0004_0000);
            rdchk(HWS, 32'h0);
        end
        $display("test detach done");
        apb(1'h1, HWS, 32'h0001_8000);
        @(posedge clock);
        #1 check({30'h0, descriptorFromRam, resetProtect}, 32'h3);
        rdchk(HWS, 32'h0001_8000);
        eepromPresent <= 1'h1;
        repeat (2) @(posedge clock);
        #1 check({31'h0, descriptorFromRam}, 32'h0);
        eepromPresent <= 1'h0;
        pulseSoftReset();
        rdchk(HWS, 32'h0001_8000);
        apb(1'h1, HWS, 32'h0001_0000);
        pulseSoftReset();
        rdchk(HWS, 32'h0);
        pstrb <= 4'h4;
        apb(1'h1, HWS, 32'h0001_8000);
        pstrb <= 4'hf;
        rdchk(HWS, 32'h0001_0000);
        $display("test setup done");
        completeRun();
    end
endmodule : tx_control_and_hw_config_bench
